// File: exp_port_pkg.sv
// Constants, types and helpers shared by the expansion port pin control
//
// Notes on behaviour
// - Each pin of the two general I/O ports can be an input or an output.
// - First port direction bit 0 turns the output on, 1 turns it off; reset FFH.
// - Direction and mode control registers take byte writes and single bits.
// - In expansion mode the first port pins carry upper address lines.
// - Mode codes x0xx keep port pins; x100 to x111 add address pairs 16-23.
// - External boot modes and single-chip mode 1 reset the mode field to 0111.
// - The second port is input only and has no direction control.
// - Second port pins feed the converter and read back as logic levels.
// - Third port pins give select/row strobes 0-7, pin 4 write, pin 5 read.
// - Mode pins and the mode control register pick control; direction else.
// - Third port mode bit 0 gives general I/O, 1 gives the select output.
// - Pins 4 and 5 in control mode use the function select register.
// - Third port mode control resets 00H in single-chip 0, else FFH.
// - Function select bit 1 picks the I/O strobe, 0 the select output.
// - In port mode the function select bit of that pin is ignored.
package exp_port_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] PORT_SIX_DIR_ADDR = 32'hFFFFF02C;
  localparam logic [31:0] PORT_EIGHT_DIR_ADDR = 32'hFFFFF030;
  localparam logic [31:0] MODE_FIELD_ADDR = 32'hFFFFF04C;
  localparam logic [31:0] PORT_EIGHT_FUNC_ADDR = 32'hFFFFF050;
  localparam logic [31:0] PORT_EIGHT_SEL_ADDR = 32'hFFFFF590;
  localparam logic [31:0] PORT_SIX_DATA_ADDR = 32'hFFFFF100;
  localparam logic [31:0] PORT_SEVEN_DATA_ADDR = 32'hFFFFF104;
  localparam logic [31:0] PORT_EIGHT_DATA_ADDR = 32'hFFFFF108;
  localparam logic [31:0] BIT_ACCESS_ADDR = 32'hFFFFF10C;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] FUNC_SC0_RST = 8'h00;
  localparam logic [7:0] FUNC_EXT_RST = 8'hFF;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [7:0] SEL_MASK = 8'h30;
  localparam logic [7:0] ALL_MASK = 8'hFF;
  localparam logic [7:0] DATA_RST = 8'h00;
  localparam logic [3:0] MODE_EXT_RST = 4'h7;
  localparam logic [3:0] MODE_SC0_RST = 4'h0;

  // ----------------------------------------------------------------
  // Boot mode pin codes, pin and field positions
  // ----------------------------------------------------------------
  localparam logic [3:0] BOOT_SINGLE0 = 4'h0;
  localparam logic [3:0] BOOT_EXT0 = 4'h1;
  localparam logic [3:0] BOOT_EXT1 = 4'h2;
  localparam logic [3:0] BOOT_SINGLE1 = 4'h3;
  localparam int WR_PIN = 4;
  localparam int RD_PIN = 5;
  localparam int BIT_VAL_POS = 0;
  localparam int BIT_IDX_LSB = 4;
  localparam int BIT_TGT_LSB = 8;

  typedef enum logic [1:0] {
    TGT_SIX_DIR = 2'h0,
    TGT_EIGHT_DIR = 2'h1,
    TGT_EIGHT_FUNC = 2'h3,
    TGT_EIGHT_SEL = 2'h2
  } bit_target_t;

  // Pins of the first port that carry address lines for a mode code
  function automatic logic [7:0] addr_pin_mask(input logic [3:0] mm);
    logic [7:0] m;
    m = 8'h00;
    if (mm[2]) begin
      unique case (mm[1:0])
        2'h0: m = 8'h03;
        2'h1: m = 8'h0F;
        2'h2: m = 8'h3F;
        2'h3: m = 8'hFF;
      endcase
    end
    return m;
  endfunction : addr_pin_mask

  // Boot modes that start with external expansion enabled
  function automatic logic ext_boot(input logic [3:0] mode);
    return (mode == BOOT_EXT0) || (mode == BOOT_EXT1) ||
      (mode == BOOT_SINGLE1);
  endfunction : ext_boot

endpackage : exp_port_pkg

// File: bit_byte_reg.sv
// Eight-bit register written as a byte or as one bit
`timescale 1ns/1ps
module bit_byte_reg #(
  parameter logic [7:0] WMASK = 8'hFF
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_rst_val,
  input wire logic i_byte_we,
  input wire logic [7:0] i_wdata,
  input wire logic i_bit_we,
  input wire logic [2:0] i_bit_idx,
  input wire logic i_bit_val,
  output logic [7:0] o_q
);
  // Bits outside WMASK stay at zero
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_q <= i_rst_val & WMASK;
    end else if (i_byte_we) begin
      o_q <= i_wdata & WMASK;
    end else if (i_bit_we) begin
      o_q[i_bit_idx] <= i_bit_val & WMASK[i_bit_idx];
    end
  end
endmodule : bit_byte_reg

// File: port_pin_drive.sv
// Registered output and enable stage for one eight-pin port
`timescale 1ns/1ps
module port_pin_drive (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic [7:0] i_ctrl,
  input wire logic [7:0] i_ctrl_val,
  input wire logic [7:0] i_dir,
  input wire logic [7:0] i_data,
  output logic [7:0] o_pin,
  output logic [7:0] o_pin_oe_n
);
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_pin <= 8'h00;
      o_pin_oe_n <= 8'hFF;
    end else begin
      o_pin <= (i_ctrl & i_ctrl_val) | (~i_ctrl & i_data);
      // Control pins always drive, port pins follow direction
      o_pin_oe_n <= ~i_ctrl & i_dir;
    end
  end
endmodule : port_pin_drive

// File: expansion_port_pin_control.sv
// Pin control for the address, input-only and strobe ports, APB slave
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module expansion_port_pin_control (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic [3:0] i_boot_mode_pins,
  input wire logic [7:0] i_first_port_pins,
  output logic [7:0] o_first_port_pins,
  output logic [7:0] o_first_port_pins_oe_n,
  input wire logic [7:0] i_input_port_pins,
  input wire logic [7:0] i_third_port_pins,
  output logic [7:0] o_third_port_pins,
  output logic [7:0] o_third_port_pins_oe_n,
  input wire logic [7:0] i_upper_address_lines,
  input wire logic [7:0] i_select_row_strobe_outputs,
  input wire logic i_io_write_strobe,
  input wire logic i_io_read_strobe,
  output logic [3:0] o_memory_expansion_mode_field
);
  import exp_port_pkg::*;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic setup;
  logic wr_en;
  logic hit;
  logic sel_six_dir, sel_eight_dir, sel_mode, sel_func, sel_sel;
  logic sel_six_dat, sel_seven_dat, sel_eight_dat, sel_bit;
  logic bit_we;
  bit_target_t bit_tgt;
  logic [2:0] bit_idx;
  logic bit_val;
  logic [7:0] wbyte;

  assign setup = i_psel & ~i_penable;
  assign wr_en = i_psel & i_penable & o_pready & i_pwrite & i_pstrb[0];
  assign wbyte = i_pwdata[7:0];
  assign sel_six_dir = (i_paddr == PORT_SIX_DIR_ADDR);
  assign sel_eight_dir = (i_paddr == PORT_EIGHT_DIR_ADDR);
  assign sel_mode = (i_paddr == MODE_FIELD_ADDR);
  assign sel_func = (i_paddr == PORT_EIGHT_FUNC_ADDR);
  assign sel_sel = (i_paddr == PORT_EIGHT_SEL_ADDR);
  assign sel_six_dat = (i_paddr == PORT_SIX_DATA_ADDR);
  assign sel_seven_dat = (i_paddr == PORT_SEVEN_DATA_ADDR);
  assign sel_eight_dat = (i_paddr == PORT_EIGHT_DATA_ADDR);
  assign sel_bit = (i_paddr == BIT_ACCESS_ADDR);
  assign hit = sel_six_dir | sel_eight_dir | sel_mode | sel_func |
    sel_sel | sel_six_dat | sel_seven_dat | sel_eight_dat | sel_bit;

  // Single-bit access names a register, a bit and a value
  assign bit_we = wr_en & sel_bit;
  assign bit_tgt = bit_target_t'(i_pwdata[BIT_TGT_LSB+:2]);
  assign bit_idx = i_pwdata[BIT_IDX_LSB+:3];
  assign bit_val = i_pwdata[BIT_VAL_POS];

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] six_dir_q, eight_dir_q, func_q, sel_q;
  logic [7:0] six_dat_q, eight_dat_q;
  logic [3:0] mode_q;
  logic ext_start;

  assign ext_start = ext_boot(i_boot_mode_pins);

  bit_byte_reg #(.WMASK(ALL_MASK)) u_six_dir (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_rst_val(DIR_RST),
    .i_byte_we(wr_en & sel_six_dir),
    .i_wdata(wbyte),
    .i_bit_we(bit_we & (bit_tgt == TGT_SIX_DIR)),
    .i_bit_idx(bit_idx),
    .i_bit_val(bit_val),
    .o_q(six_dir_q)
  );

  bit_byte_reg #(.WMASK(ALL_MASK)) u_eight_dir (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_rst_val(DIR_RST),
    .i_byte_we(wr_en & sel_eight_dir),
    .i_wdata(wbyte),
    .i_bit_we(bit_we & (bit_tgt == TGT_EIGHT_DIR)),
    .i_bit_idx(bit_idx),
    .i_bit_val(bit_val),
    .o_q(eight_dir_q)
  );

  bit_byte_reg #(.WMASK(ALL_MASK)) u_func (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_rst_val(ext_start ? FUNC_EXT_RST : FUNC_SC0_RST),
    .i_byte_we(wr_en & sel_func),
    .i_wdata(wbyte),
    .i_bit_we(bit_we & (bit_tgt == TGT_EIGHT_FUNC)),
    .i_bit_idx(bit_idx),
    .i_bit_val(bit_val),
    .o_q(func_q)
  );

  bit_byte_reg #(.WMASK(SEL_MASK)) u_sel (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_rst_val(SEL_RST),
    .i_byte_we(wr_en & sel_sel),
    .i_wdata(wbyte),
    .i_bit_we(bit_we & (bit_tgt == TGT_EIGHT_SEL)),
    .i_bit_idx(bit_idx),
    .i_bit_val(bit_val),
    .o_q(sel_q)
  );

  // Output latches of the two I/O ports
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      six_dat_q <= DATA_RST;
      eight_dat_q <= DATA_RST;
    end else begin
      if (wr_en & sel_six_dat) begin
        six_dat_q <= wbyte;
      end
      if (wr_en & sel_eight_dat) begin
        eight_dat_q <= wbyte;
      end
    end
  end

  // Expansion mode field, preset from the boot mode pins
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      mode_q <= ext_start ? MODE_EXT_RST : MODE_SC0_RST;
    end else if (wr_en & sel_mode) begin
      mode_q <= i_pwdata[3:0];
    end
  end

  assign o_memory_expansion_mode_field = mode_q;

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [1:0] rd_tgt_q;
  logic [2:0] rd_idx_q;
  logic [7:0] bit_src;
  logic [7:0] rdata_d;

  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      rd_tgt_q <= 2'h0;
      rd_idx_q <= 3'h0;
    end else if (bit_we) begin
      rd_tgt_q <= bit_tgt;
      rd_idx_q <= bit_idx;
    end
  end

  always_comb begin
    unique case (bit_target_t'(rd_tgt_q))
      TGT_SIX_DIR: bit_src = six_dir_q;
      TGT_EIGHT_DIR: bit_src = eight_dir_q;
      TGT_EIGHT_FUNC: bit_src = func_q;
      TGT_EIGHT_SEL: bit_src = sel_q;
    endcase
  end

  // Input pins read their level, output pins their latch
  always_comb begin
    rdata_d = 8'h00;
    if (sel_six_dir) rdata_d = six_dir_q;
    if (sel_eight_dir) rdata_d = eight_dir_q;
    if (sel_mode) rdata_d = {4'h0, mode_q};
    if (sel_func) rdata_d = func_q;
    if (sel_sel) rdata_d = sel_q;
    if (sel_six_dat) begin
      rdata_d = (six_dir_q & i_first_port_pins) | (~six_dir_q & six_dat_q);
    end
    if (sel_seven_dat) rdata_d = i_input_port_pins;
    if (sel_eight_dat) begin
      rdata_d = (eight_dir_q & i_third_port_pins) |
        (~eight_dir_q & eight_dat_q);
    end
    if (sel_bit) rdata_d = {7'h00, bit_src[rd_idx_q]};
  end

  // Answer one cycle after the setup cycle
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata <= 32'h0000_0000;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup & ~hit;
      o_prdata <= setup ? {24'h000000, rdata_d} : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------
  // Pin functions
  // ----------------------------------------------------------------
  logic [7:0] addr_ctrl;
  logic [7:0] strobe_val;

  assign addr_ctrl = addr_pin_mask(mode_q);

  // Pins 4 and 5 pick the I/O strobe when their select bit is set
  always_comb begin
    strobe_val = i_select_row_strobe_outputs;
    if (sel_q[WR_PIN]) strobe_val[WR_PIN] = i_io_write_strobe;
    if (sel_q[RD_PIN]) strobe_val[RD_PIN] = i_io_read_strobe;
  end

  port_pin_drive u_six_drive (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_ctrl(addr_ctrl),
    .i_ctrl_val(i_upper_address_lines),
    .i_dir(six_dir_q),
    .i_data(six_dat_q),
    .o_pin(o_first_port_pins),
    .o_pin_oe_n(o_first_port_pins_oe_n)
  );

  port_pin_drive u_eight_drive (
    .i_ref_clk(i_ref_clk),
    .i_srst(i_srst),
    .i_ctrl(func_q),
    .i_ctrl_val(strobe_val),
    .i_dir(eight_dir_q),
    .i_data(eight_dat_q),
    .o_pin(o_third_port_pins),
    .o_pin_oe_n(o_third_port_pins_oe_n)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_srst);

  sequence reset_done_s;
    $past(i_srst) && !i_srst;
  endsequence

  sequence setup_at_s(logic [31:0] a);
    i_psel && !i_penable && i_paddr == a && !i_pwrite;
  endsequence

  dir_reset_a: assert property (reset_done_s |-> six_dir_q == DIR_RST)
    else $error("first port direction not FFH after reset");

  func_reset_a: assert property (reset_done_s |->
    func_q == (ext_boot($past(i_boot_mode_pins)) ? FUNC_EXT_RST
      : FUNC_SC0_RST))
    else $error("mode control reset value wrong for boot mode");

  mode_reset_a: assert property (reset_done_s |->
    ext_boot($past(i_boot_mode_pins)) == (mode_q[2:0] == 3'h7))
    else $error("expansion field reset value wrong");

  addr_pin_a: assert property (mode_q[2] && mode_q[1:0] == 2'h0
    |=> o_first_port_pins_oe_n[1:0] == 2'h0 &&
      o_first_port_pins[1:0] == $past(i_upper_address_lines[1:0]) &&
      o_first_port_pins_oe_n[7:2] == $past(six_dir_q[7:2]))
    else $error("address pins 16-17 not driven in code 100");

  addr_off_a: assert property (!mode_q[2]
    |=> o_first_port_pins_oe_n == $past(six_dir_q))
    else $error("first port left port mode without expansion");

  io_write_strobe_pin_a: assert property (func_q[WR_PIN] && sel_q[WR_PIN]
    |=> !o_third_port_pins_oe_n[WR_PIN] &&
      o_third_port_pins[WR_PIN] == $past(i_io_write_strobe))
    else $error("pin 4 not carrying the write strobe");

  sel_ignored_a: assert property (!func_q[RD_PIN]
    |=> o_third_port_pins[RD_PIN] == $past(eight_dat_q[RD_PIN]))
    else $error("function select acted in port mode");

  in_read_a: assert property (setup_at_s(PORT_SEVEN_DATA_ADDR)
    |=> o_pready && o_prdata[7:0] == $past(i_input_port_pins))
    else $error("input port read not equal to pin levels");

  bit_write_a: assert property (bit_we && bit_tgt == TGT_SIX_DIR
    ##1 !bit_we [*2] |-> six_dir_q[$past(bit_idx, 2)] == $past(bit_val, 2))
    else $error("single bit write did not land");

  unmapped_a: assert property (setup && !hit
    |=> o_pready && o_pslverr && o_prdata == 32'h0000_0000)
    else $error("unmapped address not refused");

endmodule : expansion_port_pin_control

// File: exp_bus_partner.sv
// Expansion bus side model: bus controller outputs and pin levels
`timescale 1ns/1ps
module exp_bus_partner #(
  parameter logic [7:0] ADDR_VAL = 8'hA5,
  parameter logic [7:0] STRB_VAL = 8'h3C,
  parameter logic [7:0] ANA_VAL = 8'h96,
  parameter logic IO_WR = 1'b0,
  parameter logic IO_RD = 1'b1,
  parameter logic [7:0] EXT_VAL = 8'h69
) (
  input wire logic [7:0] i_first_out,
  input wire logic [7:0] i_first_oe_n,
  input wire logic [7:0] i_third_out,
  input wire logic [7:0] i_third_oe_n,
  output logic [7:0] o_first_in,
  output logic [7:0] o_third_in,
  output logic [7:0] o_addr,
  output logic [7:0] o_strb,
  output logic o_io_wr,
  output logic o_io_rd,
  output logic [7:0] o_analog
);
  // Released pins show the level the external devices put on them
  assign o_first_in = (i_first_out & ~i_first_oe_n) | (EXT_VAL & i_first_oe_n);
  assign o_third_in = (i_third_out & ~i_third_oe_n) | (EXT_VAL & i_third_oe_n);
  assign o_addr = ADDR_VAL;
  assign o_strb = STRB_VAL;
  assign o_io_wr = IO_WR;
  assign o_io_rd = IO_RD;
  assign o_analog = ANA_VAL;
endmodule : exp_bus_partner

// File: test_expansion_port_pin_control.sv
// Self-checking bench for the expansion port pin control block
`timescale 1ns/1ps
module test_expansion_port_pin_control;
  import exp_port_pkg::*;
  localparam logic [7:0] ADDR_VAL = 8'hA5;
  localparam logic [7:0] STRB_VAL = 8'h3C;
  localparam logic [7:0] ANA_VAL = 8'h96;
  localparam logic [7:0] EXT_VAL = 8'h69;
  localparam logic IO_WR = 1'b0;
  localparam logic IO_RD = 1'b1;
  localparam logic [31:0] BAD_ADDR = 32'hFFFFF000;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, last_err;
  logic io_wr, io_rd;
  logic [31:0] paddr, pwdata, prdata, last_rd;
  logic [3:0] pstrb, boot, mode_out;
  logic [7:0] p1_in, p1_out, p1_oe_n, p3_in, p3_out, p3_oe_n;
  logic [7:0] addr, strb, analog, m;
  int num_errors = 0;
  int samples_checked = 0;

  expansion_port_pin_control u_dut (
    .i_ref_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(penable),
    .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_boot_mode_pins(boot),
    .i_first_port_pins(p1_in), .o_first_port_pins(p1_out),
    .o_first_port_pins_oe_n(p1_oe_n), .i_input_port_pins(analog),
    .i_third_port_pins(p3_in), .o_third_port_pins(p3_out),
    .o_third_port_pins_oe_n(p3_oe_n), .i_upper_address_lines(addr),
    .i_select_row_strobe_outputs(strb), .i_io_write_strobe(io_wr),
    .i_io_read_strobe(io_rd), .o_memory_expansion_mode_field(mode_out)
  );

  exp_bus_partner #(.ADDR_VAL(ADDR_VAL), .STRB_VAL(STRB_VAL),
    .ANA_VAL(ANA_VAL), .IO_WR(IO_WR), .IO_RD(IO_RD),
    .EXT_VAL(EXT_VAL)) u_far (
    .i_first_out(p1_out), .i_first_oe_n(p1_oe_n),
    .i_third_out(p3_out), .i_third_oe_n(p3_oe_n), .o_first_in(p1_in),
    .o_third_in(p3_in), .o_addr(addr), .o_strb(strb), .o_io_wr(io_wr),
    .o_io_rd(io_rd), .o_analog(analog)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input string name, input logic [31:0] exp,
                     input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // Setup, then access held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) num_errors++;
    last_rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb

  task automatic rd(input string name, input logic [31:0] a,
                    input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(name, exp, last_rd);
  endtask : rd

  // Driven pins carry val; enables must equal oe
  task automatic pins(input bit third, input logic [7:0] oe,
                      input logic [7:0] val);
    logic [7:0] o, n;
    @(posedge clk);
    o = third ? p3_out : p1_out;
    n = third ? p3_oe_n : p1_oe_n;
    chk("pin enable", {24'h0, oe}, {24'h0, n});
    chk("pin value", {24'h0, val & ~oe}, {24'h0, o & ~oe});
  endtask : pins

  task automatic do_reset(input logic [3:0] code);
    boot <= code;
    srst <= 1'b1;
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
  endtask : do_reset

  task automatic wrap_up();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : wrap_up

  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    wrap_up();
  end

  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 32'h0;
    pwdata = 32'h0;
    pstrb = 4'hF;
    boot = BOOT_SINGLE0;
    do_reset(BOOT_SINGLE0);
    rd("first dir", PORT_SIX_DIR_ADDR, 32'hFF);
    rd("third dir", PORT_EIGHT_DIR_ADDR, 32'hFF);
    rd("mode ctl", PORT_EIGHT_FUNC_ADDR, 32'h00);
    rd("func sel", PORT_EIGHT_SEL_ADDR, 32'h00);
    rd("mode field", MODE_FIELD_ADDR, 32'h0);
    pins(1'b0, 8'hFF, 8'h00);
    pins(1'b1, 8'hFF, 8'h00);
    apb(1'b1, PORT_SIX_DIR_ADDR, 32'h5A);
    apb(1'b1, PORT_SIX_DATA_ADDR, 32'hC3);
    pins(1'b0, 8'h5A, 8'hC3);
    rd("first data", PORT_SIX_DATA_ADDR,
       {24'h0, (8'h5A & EXT_VAL) | (8'hA5 & 8'hC3)});
    for (int c = 0; c < 16; c++) begin
      m = c[2] ? 8'((16'h1 << (2 * c[1:0] + 2)) - 16'h1) : 8'h00;
      apb(1'b1, MODE_FIELD_ADDR, 32'(c));
      chk("mode out", 32'(c[2:0]), {29'h0, mode_out[2:0]});
      pins(1'b0, 8'h5A & ~m, (ADDR_VAL & m) | (8'hC3 & ~m));
    end
    apb(1'b1, MODE_FIELD_ADDR, 32'h0);
    pins(1'b0, 8'h5A, 8'hC3);
    apb(1'b1, BIT_ACCESS_ADDR, 32'h0071);
    rd("first dir", PORT_SIX_DIR_ADDR, 32'hDA);
    rd("bit read", BIT_ACCESS_ADDR, 32'h1);
    apb(1'b1, BIT_ACCESS_ADDR, 32'h0201);
    apb(1'b1, BIT_ACCESS_ADDR, 32'h0251);
    rd("func sel", PORT_EIGHT_SEL_ADDR, 32'h20);
    apb(1'b1, PORT_EIGHT_SEL_ADDR, 32'hFF);
    rd("func sel", PORT_EIGHT_SEL_ADDR, 32'h30);
    rd("input port", PORT_SEVEN_DATA_ADDR, {24'h0, ANA_VAL});
    apb(1'b1, PORT_SEVEN_DATA_ADDR, 32'h00);
    rd("input port", PORT_SEVEN_DATA_ADDR, {24'h0, ANA_VAL});
    pins(1'b1, 8'hFF, 8'h00);
    rd("third data", PORT_EIGHT_DATA_ADDR, {24'h0, EXT_VAL});
    apb(1'b1, PORT_EIGHT_DIR_ADDR, 32'h00);
    apb(1'b1, PORT_EIGHT_DATA_ADDR, 32'h0F);
    pins(1'b1, 8'h00, 8'h0F);
    apb(1'b1, PORT_EIGHT_FUNC_ADDR, 32'h30);
    pins(1'b1, 8'h00, {2'b00, IO_RD, IO_WR, 4'hF});
    apb(1'b1, PORT_EIGHT_FUNC_ADDR, 32'hFF);
    apb(1'b1, PORT_EIGHT_SEL_ADDR, 32'h00);
    pins(1'b1, 8'h00, STRB_VAL);
    apb(1'b0, BAD_ADDR, 32'h0);
    chk("slave error", 32'h1, {31'h0, last_err});
    chk("bad read", 32'h0, last_rd);
    pstrb <= 4'hE;
    apb(1'b1, PORT_SIX_DIR_ADDR, 32'h00);
    pstrb <= 4'hF;
    rd("first dir", PORT_SIX_DIR_ADDR, 32'hDA);
    chk("no error", 32'h0, {31'h0, last_err});
    for (int b = 1; b < 4; b++) begin
      do_reset(4'(b));
      rd("mode field", MODE_FIELD_ADDR, 32'h7);
      rd("mode ctl", PORT_EIGHT_FUNC_ADDR, 32'hFF);
      pins(1'b0, 8'h00, ADDR_VAL);
      pins(1'b1, 8'h00, STRB_VAL);
    end
    wrap_up();
  end
endmodule : test_expansion_port_pin_control
